/* dv/ome_clk_force_assertions.sv */
`timescale 1ns/1ps
module ome_clk_force_chk (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire [4:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        conv_mod_req_in,
  input wire        ext_run_out,
  input wire        conv_run_out,
  input wire        ext_ready_out,
  input wire        conv_ready_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire man_wr = avs_write_in && avs_waitrequest_out && avs_address_in == 5'h00 && avs_byteenable_in[0];
  wire man_rd = avs_read_in && avs_waitrequest_out && avs_address_in == 5'h00;
  ext_force_a: assert property (man_wr && avs_writedata_in[7] |-> ##2 ext_run_out)
    else $error("ext run not forced by manual bit");
  conv_force_a: assert property (man_wr && avs_writedata_in[2] |-> ##2 conv_run_out)
    else $error("conv run not forced by manual bit");
  conv_merge_a: assert property (conv_mod_req_in |=> conv_run_out)
    else $error("conv module request not merged");
  reset_clear_a: assert property ($rose(rst_b_in) |-> !ext_run_out && !conv_run_out)
    else $error("run not cleared by reset");
  rsvd_bits_a: assert property (man_rd |=> avs_readdata_out[5] == 1'b0 && avs_readdata_out[1:0] == 2'h0)
    else $error("unused manual bits read nonzero");
  conv_early_a: assert property ($rose(conv_run_out) |-> !conv_ready_out [*8])
    else $error("conv ready before start-up");
  conv_drop_a: assert property (!conv_run_out |=> !conv_ready_out)
    else $error("conv ready while disabled");
  ext_drop_a: assert property (!ext_run_out |=> !ext_ready_out)
    else $error("ext ready while disabled");
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  bus_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("bus answer longer than one cycle");
  cover property (man_wr);
  cover property ($rose(conv_ready_out));
  cover property ($rose(ext_ready_out));
endmodule
bind ome_clk_force ome_clk_force_chk u_chk (.*);

/* dv/ome_clk_force_tb.sv */
`timescale 1ns/1ps
`include "ome_defines.vh"
module ome_clk_force_tb;
  logic        clk_in, rst_b_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
  logic [3:0]  avs_byteenable_in;
  logic [1:0]  avs_response_out, rresp;
  logic        ext_mod_req_in, fast_mod_req_in, slow_mod_req_in, sec_mod_req_in, conv_mod_req_in;
  logic        ext_run_out, fast_run_out, slow_run_out, sec_run_out, conv_run_out;
  logic        ext_ready_out, fast_ready_out, slow_ready_out, sec_ready_out, conv_ready_out;
  logic [2:0]  external_clock_mode_cfg_out, fast_clock_freq_select_out;
  logic        secondary_clk_buffer_en_out, secondary_clk_power_sel_out;
  int          errors = 0, samples_checked = 0, cycles = 0;
  wire  [4:0]  runs = {ext_run_out, fast_run_out, slow_run_out, sec_run_out, conv_run_out};
  ome_clk_force u_dut (.*);
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // the request is held until the edge that samples waitrequest low; data and response are taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_in);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do @(posedge clk_in); while (avs_waitrequest_out);
    rdata = avs_readdata_out;
    rresp = avs_response_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(nm, exp, rdata);
    chk("read resp", {30'h0, `OME_RESP_OK}, {30'h0, rresp});
  endtask
  task automatic setreq(input logic [4:0] v);
    @(posedge clk_in);
    {ext_mod_req_in, fast_mod_req_in, slow_mod_req_in, sec_mod_req_in, conv_mod_req_in} <= v;
  endtask
  function automatic logic [31:0] img(input logic [4:0] v);
    return {24'h0, v[4:3], 1'b0, v[2:0], 2'h0};
  endfunction
  task automatic t_reset();
    rd(`OME_ADDR_MANUAL, 32'h0, "manual reset");
    @(negedge clk_in);
    chk("run reset", 32'h0, runs);
    chk("config reset", 32'h18, {external_clock_mode_cfg_out, fast_clock_freq_select_out,
        secondary_clk_buffer_en_out, secondary_clk_power_sel_out});
  endtask
  task automatic t_manual();
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `OME_ADDR_MANUAL, img(5'h1 << i), 4'hF);
      @(negedge clk_in);
      chk("run manual", 32'h1 << i, runs);
    end
    bus(1'b1, `OME_ADDR_MANUAL, 32'hFF, 4'hF);
    rd(`OME_ADDR_MANUAL, 32'hDC, "manual unused");
    bus(1'b1, `OME_ADDR_MANUAL, 32'h0, 4'h0);
    rd(`OME_ADDR_MANUAL, 32'hDC, "manual no lane");
    bus(1'b1, `OME_ADDR_MANUAL, 32'h0, 4'hF);
  endtask
  task automatic t_merge();
    for (int i = 0; i < 5; i++) begin
      setreq(5'h1 << i);
      @(posedge clk_in);
      @(negedge clk_in);
      chk("run request", 32'h1 << i, runs);
    end
    rd(`OME_ADDR_MOD_REQ, img(5'h10), "request word");
    rd(`OME_ADDR_RUN, img(5'h10), "run word");
    setreq(5'h0);
    @(posedge clk_in);
    @(negedge clk_in);
    chk("run idle", 32'h0, runs);
  endtask
  task automatic t_ready();
    bus(1'b1, `OME_ADDR_MANUAL, 32'hDC, 4'hF);
    rd(`OME_ADDR_READY, 32'h0, "ready early");
    repeat (200) @(posedge clk_in);
    rd(`OME_ADDR_READY, 32'hDC, "ready stable");
    chk("ready pins", 32'h1F, {ext_ready_out, fast_ready_out, slow_ready_out, sec_ready_out, conv_ready_out});
    bus(1'b1, `OME_ADDR_MANUAL, 32'h0, 4'hF);
    repeat (3) @(posedge clk_in);
    rd(`OME_ADDR_READY, 32'h0, "ready off");
  endtask
  task automatic t_cfg();
    bus(1'b1, `OME_ADDR_EXT_MODE, 32'h5, 4'hF);
    bus(1'b1, `OME_ADDR_FREQ_SEL, 32'h3, 4'hF);
    bus(1'b1, `OME_ADDR_FREQ_SEL, 32'h7, 4'hF);
    bus(1'b1, `OME_ADDR_CTRL3, 32'h60, 4'hF);
    @(negedge clk_in);
    chk("config", 32'hAF, {external_clock_mode_cfg_out, fast_clock_freq_select_out,
        secondary_clk_buffer_en_out, secondary_clk_power_sel_out});
    rd(`OME_ADDR_FREQ_SEL, 32'h3, "freq keep");
    rd(`OME_ADDR_CTRL3, 32'h60, "ctrl3 word");
    bus(1'b0, 5'h1C, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rdata);
    chk("unmapped resp", {30'h0, `OME_RESP_SLVERR}, {30'h0, rresp});
  endtask
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_b_in = 1'b0;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
    {ext_mod_req_in, fast_mod_req_in, slow_mod_req_in, sec_mod_req_in, conv_mod_req_in} = '0;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_manual();
    t_merge();
    t_ready();
    t_cfg();
    test_done();
  end
endmodule

/* verilog/ome_clk_force.v */
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ome_defines.vh"
module ome_clk_force (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  input  wire        ext_mod_req_in,
  input  wire        fast_mod_req_in,
  input  wire        slow_mod_req_in,
  input  wire        sec_mod_req_in,
  input  wire        conv_mod_req_in,
  output wire        ext_run_out,
  output wire        fast_run_out,
  output wire        slow_run_out,
  output wire        sec_run_out,
  output wire        conv_run_out,
  output wire        ext_ready_out,
  output wire        fast_ready_out,
  output wire        slow_ready_out,
  output wire        sec_ready_out,
  output wire        conv_ready_out,
  output reg  [2:0]  external_clock_mode_cfg_out,
  output reg  [2:0]  fast_clock_freq_select_out,
  output reg         secondary_clk_buffer_en_out,
  output reg         secondary_clk_power_sel_out
);

  // five-bit vectors are ordered ext, fast, slow, secondary, converter from msb to lsb
  reg  [4:0] manual_q;
  reg  [4:0] manual_d;
  reg  [4:0] mod_req_q;
  wire [4:0] run_w;
  wire [4:0] ready_w;
  wire [4:0] mod_req_w;

  wire       req_w;
  wire       take_w;
  wire       lane0_we_w;
  wire       hit_w;
  reg  [31:0] rdata_d;

  reg  [2:0] ext_mode_d;
  reg  [2:0] freq_sel_d;
  reg        sec_buf_d;
  reg        sec_pwr_d;

  // spreads a five-bit source vector onto the 8-bit register layout, unused bits zero
  function [7:0] ome_pack;
    input [4:0] v;
    begin
      ome_pack                = 8'h00;
      ome_pack[`OME_BIT_EXT]  = v[4];
      ome_pack[`OME_BIT_FAST] = v[3];
      ome_pack[`OME_BIT_SLOW] = v[2];
      ome_pack[`OME_BIT_SEC]  = v[1];
      ome_pack[`OME_BIT_CONV] = v[0];
    end
  endfunction

  // gathers the five source bits back out of an 8-bit register image
  function [4:0] ome_unpack;
    input [7:0] b;
    begin
      ome_unpack = {b[`OME_BIT_EXT], b[`OME_BIT_FAST], b[`OME_BIT_SLOW], b[`OME_BIT_SEC], b[`OME_BIT_CONV]};
    end
  endfunction

  // true for an address that maps onto a register word
  function ome_mapped;
    input [4:0] a;
    begin
      case (a)
        `OME_ADDR_MANUAL:   ome_mapped = 1'b1;
        `OME_ADDR_READY:    ome_mapped = 1'b1;
        `OME_ADDR_MOD_REQ:  ome_mapped = 1'b1;
        `OME_ADDR_RUN:      ome_mapped = 1'b1;
        `OME_ADDR_EXT_MODE: ome_mapped = 1'b1;
        `OME_ADDR_FREQ_SEL: ome_mapped = 1'b1;
        `OME_ADDR_CTRL3:    ome_mapped = 1'b1;
        default:            ome_mapped = 1'b0;
      endcase
    end
  endfunction

  assign mod_req_w = {ext_mod_req_in, fast_mod_req_in, slow_mod_req_in, sec_mod_req_in, conv_mod_req_in};

  // bus handshake: a request is taken only while waitrequest is high, then answered one cycle later
  assign req_w      = avs_read_in | avs_write_in;
  assign take_w     = req_w & avs_waitrequest_out;
  assign hit_w      = ome_mapped(avs_address_in);
  assign lane0_we_w = take_w & avs_write_in & avs_byteenable_in[0];

  // manual request register
  always @* begin
    manual_d = manual_q;
    if (lane0_we_w && avs_address_in == `OME_ADDR_MANUAL) begin
      // only implemented positions are stored; bits 5, 1 and 0 have no storage
      manual_d = ome_unpack(avs_writedata_in[7:0] & `OME_MANUAL_MASK);
    end
  end

  // clock source configuration that the forced sources run with
  always @* begin
    ext_mode_d = external_clock_mode_cfg_out;
    freq_sel_d = fast_clock_freq_select_out;
    sec_buf_d  = secondary_clk_buffer_en_out;
    sec_pwr_d  = secondary_clk_power_sel_out;
    if (lane0_we_w && avs_address_in == `OME_ADDR_EXT_MODE) begin
      ext_mode_d = avs_writedata_in[2:0];
    end
    if (lane0_we_w && avs_address_in == `OME_ADDR_FREQ_SEL) begin
      // reserved codes are dropped so the fast oscillator never runs at an undefined rate
      if (avs_writedata_in[2:0] != `OME_FREQ_RSVD_A && avs_writedata_in[2:0] != `OME_FREQ_RSVD_B) begin
        freq_sel_d = avs_writedata_in[2:0];
      end
    end
    if (lane0_we_w && avs_address_in == `OME_ADDR_CTRL3) begin
      sec_buf_d = avs_writedata_in[`OME_BIT_SEC_BUF];
      sec_pwr_d = avs_writedata_in[`OME_BIT_SEC_PWR];
    end
  end

  // read data mux
  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address_in)
      `OME_ADDR_MANUAL:   rdata_d[7:0] = ome_pack(manual_q);
      `OME_ADDR_READY:    rdata_d[7:0] = ome_pack(ready_w);
      `OME_ADDR_MOD_REQ:  rdata_d[7:0] = ome_pack(mod_req_q);
      `OME_ADDR_RUN:      rdata_d[7:0] = ome_pack(run_w);
      `OME_ADDR_EXT_MODE: rdata_d[2:0] = external_clock_mode_cfg_out;
      `OME_ADDR_FREQ_SEL: rdata_d[2:0] = fast_clock_freq_select_out;
      `OME_ADDR_CTRL3: begin
        rdata_d[`OME_BIT_SEC_BUF] = secondary_clk_buffer_en_out;
        rdata_d[`OME_BIT_SEC_PWR] = secondary_clk_power_sel_out;
      end
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      manual_q                    <= `OME_MANUAL_RST;
      mod_req_q                   <= 5'h00;
      external_clock_mode_cfg_out <= `OME_EXT_MODE_RST;
      fast_clock_freq_select_out  <= `OME_FREQ_SEL_RST;
      secondary_clk_buffer_en_out <= `OME_SEC_BUF_RST;
      secondary_clk_power_sel_out <= `OME_SEC_PWR_RST;
    end else begin
      manual_q                    <= manual_d;
      mod_req_q                   <= mod_req_w;
      external_clock_mode_cfg_out <= ext_mode_d;
      fast_clock_freq_select_out  <= freq_sel_d;
      secondary_clk_buffer_en_out <= sec_buf_d;
      secondary_clk_power_sel_out <= sec_pwr_d;
    end
  end

  // waitrequest idles high; it drops for exactly the one cycle that answers a taken request
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      avs_response_out    <= `OME_RESP_OK;
    end else if (take_w) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= avs_read_in ? rdata_d : 32'h0000_0000;
      avs_response_out    <= hit_w ? `OME_RESP_OK : `OME_RESP_SLVERR;
    end else begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      avs_response_out    <= `OME_RESP_OK;
    end
  end

  // the merge registers the OR so the run outputs never glitch with request edges
  ome_req_merge u_merge (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .manual_in  (manual_q),
    .mod_req_in (mod_req_w),
    .run_out    (run_w)
  );

  assign ext_run_out  = run_w[4];
  assign fast_run_out = run_w[3];
  assign slow_run_out = run_w[2];
  assign sec_run_out  = run_w[1];
  assign conv_run_out = run_w[0];

  ome_osc_start #(
    .START_CYCLES (`OME_START_EXT)
  ) u_start_ext (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .run_in    (run_w[4]),
    .ready_out (ready_w[4])
  );

  ome_osc_start #(
    .START_CYCLES (`OME_START_FAST)
  ) u_start_fast (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .run_in    (run_w[3]),
    .ready_out (ready_w[3])
  );

  ome_osc_start #(
    .START_CYCLES (`OME_START_SLOW)
  ) u_start_slow (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .run_in    (run_w[2]),
    .ready_out (ready_w[2])
  );

  ome_osc_start #(
    .START_CYCLES (`OME_START_SEC)
  ) u_start_sec (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .run_in    (run_w[1]),
    .ready_out (ready_w[1])
  );

  ome_osc_start #(
    .START_CYCLES (`OME_START_CONV)
  ) u_start_conv (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .run_in    (run_w[0]),
    .ready_out (ready_w[0])
  );

  assign ext_ready_out  = ready_w[4];
  assign fast_ready_out = ready_w[3];
  assign slow_ready_out = ready_w[2];
  assign sec_ready_out  = ready_w[1];
  assign conv_ready_out = ready_w[0];

endmodule

/* verilog/ome_defines.vh */
`ifndef OME_DEFINES_VH
`define OME_DEFINES_VH

// byte addresses of the register words
`define OME_ADDR_MANUAL      5'h00
`define OME_ADDR_READY       5'h04
`define OME_ADDR_MOD_REQ     5'h08
`define OME_ADDR_RUN         5'h0C
`define OME_ADDR_EXT_MODE    5'h10
`define OME_ADDR_FREQ_SEL    5'h14
`define OME_ADDR_CTRL3       5'h18

// bit positions inside an 8-bit register image
`define OME_BIT_EXT          7
`define OME_BIT_FAST         6
`define OME_BIT_SLOW         4
`define OME_BIT_SEC          3
`define OME_BIT_CONV         2
`define OME_BIT_SEC_PWR      6
`define OME_BIT_SEC_BUF      5

// writable bit mask of the manual request register
`define OME_MANUAL_MASK      8'hDC

// reset values
`define OME_MANUAL_RST       5'h00
`define OME_EXT_MODE_RST     3'h0
`define OME_FREQ_SEL_RST     3'h6
`define OME_SEC_BUF_RST      1'h0
`define OME_SEC_PWR_RST      1'h0

// reserved frequency selection codes
`define OME_FREQ_RSVD_A      3'h2
`define OME_FREQ_RSVD_B      3'h7

// start-up delay of each source in clock cycles
`define OME_START_EXT        8'h80
`define OME_START_FAST       8'h10
`define OME_START_SLOW       8'h20
`define OME_START_SEC        8'hC0
`define OME_START_CONV       8'h08

// avalon response codes
`define OME_RESP_OK          2'h0
`define OME_RESP_SLVERR      2'h2

`endif

/* verilog/ome_osc_start.v */
`timescale 1ns/1ps
module ome_osc_start #(
  parameter [7:0] START_CYCLES = 8'h10
) (
  input  wire clk_in,
  input  wire rst_b_in,
  input  wire run_in,
  output reg  ready_out
);
  reg [7:0] cnt_q;

  // the count restarts from zero whenever the source stops, so a brief stop costs a full start-up
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q     <= 8'h00;
      ready_out <= 1'b0;
    end else if (!run_in) begin
      cnt_q     <= 8'h00;
      ready_out <= 1'b0;
    end else if (cnt_q != START_CYCLES) begin
      cnt_q     <= cnt_q + 8'h01;
      ready_out <= 1'b0;
    end else begin
      ready_out <= 1'b1;
    end
  end
endmodule

/* verilog/ome_req_merge.v */
`timescale 1ns/1ps
module ome_req_merge (
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire [4:0] manual_in,
  input  wire [4:0] mod_req_in,
  output reg  [4:0] run_out
);
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      run_out <= 5'h00;
    end else begin
      run_out <= manual_in | mod_req_in;
    end
  end
endmodule
